// ---- core/uctl_top.v ----
// serial port status/control, transmit buffer and receive side
// Contract
// - codec off: invert bit set idles output low, clear idles high
// - codec on: invert bit set idles output high, clear idles low
// - break request sends start, twelve zeros, stop; hardware then clears it
// - clearing transmit enable aborts, empties buffer, releases output pin
// - buffer full flag is 1 when no space, 0 when space remains
// - shift empty flag is 1 only when shifter and buffer both empty
// - first variant: rx event at four, at three, or every character
// - second variant: rx level at four or more, at three or more, or at least one
// - station detect mode acts only in nine-bit mode
// - receiver idle flag is 1 unless a character is arriving
// - parity error flag reflects the current received character
// - framing error flag reflects the current received character
// - overrun set by hardware, cleared by software; clearing flushes receive side
// - data available flag is 1 while the receive buffer holds data
// - clear, set and invert aliases at plus 4, 8 and 12
// - transmit holding register takes nine bits, upper bits ignored
// - select code 11 means nine data bits without parity
// - codec enable bit chooses which idle polarity applies
`timescale 1ns/1ps
`include "uctl_defs.vh"

module uctl_top (
	input wire clk_sys,
	input wire rst_n,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire serial_in_pin,
	output reg serial_in_owned_r,
	output reg serial_out_pin_r,
	output reg serial_out_oe_r,
	output reg tx_irq_r,
	output reg rx_irq_r
);

	// bit time cut to the counter width on purpose
	localparam integer BITC_I = `UCTL_BIT_CYC;
	localparam [15:0] BITC = BITC_I[15:0];
	localparam [1:0] RX_IDLE = 2'h0;
	localparam [1:0] RX_START = 2'h1;
	localparam [1:0] RX_DATA = 2'h2;

	// ****************************************
	// reset release
	// ****************************************
	reg rst_a_r;
	reg rst_s_n;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_a_r <= 1'b0;
			rst_s_n <= 1'b0;
		end else begin
			rst_a_r <= 1'b1;
			rst_s_n <= rst_a_r;
		end
	end

	// ****************************************
	// state declarations
	// ****************************************
	reg [31:0] ctl_r;
	reg [31:0] cfg_r;
	reg overrun_error_flag_r;
	reg aw_hold_r;
	reg w_hold_r;
	reg [7:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg [8:0] tmem_r [0:3];
	reg [1:0] twp_r;
	reg [1:0] trp_r;
	reg [2:0] tcnt_r;
	reg [2:0] tcnt_q;
	reg tx_go_r;
	reg tx_brk_r;
	reg brk_run_r;
	reg [10:0] rmem_r [0:3];
	reg [1:0] rwp_r;
	reg [1:0] rrp_r;
	reg [2:0] rcnt_r;
	reg s1_r;
	reg s2_r;
	reg s3_r;
	reg filt_r;
	reg filt_q;
	reg [1:0] rst_r;
	reg [15:0] rtick_r;
	reg [3:0] rbit_r;
	reg [8:0] rsh_r;
	reg rx_push_r;

	wire tx_line;
	wire tx_busy;
	wire tx_done;
	wire on = cfg_r[`UCTL_B_ON];
	wire infrared_codec_enable = cfg_r[`UCTL_B_INFRARED_CODEC_ENABLE];
	wire var2 = cfg_r[`UCTL_B_VAR];
	wire [1:0] pds = cfg_r[`UCTL_B_PDS_HI:`UCTL_B_PDS_LO];
	wire txen = ctl_r[`UCTL_B_TXEN];
	wire [1:0] txsel = ctl_r[`UCTL_B_TXSEL_HI:`UCTL_B_TXSEL_LO];
	wire [1:0] rxsel = ctl_r[`UCTL_B_RXSEL_HI:`UCTL_B_RXSEL_LO];
	wire [7:0] match = ctl_r[`UCTL_B_MATCH_HI:`UCTL_B_MATCH_LO];
	wire nine = (pds == `UCTL_PDS_9N);
	wire rx_on = on & ctl_r[`UCTL_B_RXEN];
	wire txbf = (tcnt_r == `UCTL_DEPTH);
	wire transmit_shift_empty = (tcnt_r == 3'h0) & ~tx_busy & ~tx_go_r;
	wire rxda = (rcnt_r != 3'h0);
	wire receiver_idle_flag = (rst_r == RX_IDLE);
	wire [10:0] rhead = rmem_r[rrp_r];
	wire [31:0] scr_rd;

	// error flags of the head character
	assign scr_rd = {ctl_r[31:10], txbf, transmit_shift_empty, ctl_r[7:5], receiver_idle_flag,
		rhead[10] & rxda, rhead[9] & rxda, overrun_error_flag_r, rxda};

	// ****************************************
	// bus write side
	// ****************************************
	wire do_wr = aw_hold_r & w_hold_r & ~s_axi_bvalid;
	wire [31:0] smask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	wire [31:0] wdm = wdata_r & smask;
	wire wr_scr = do_wr & (awaddr_r[7:4] == 4'h0);
	wire wr_txh = do_wr & (awaddr_r == `UCTL_A_TXH);
	wire wr_cfg = do_wr & (awaddr_r == `UCTL_A_CFG);
	wire wr_ok = wr_scr | wr_txh | wr_cfg | (do_wr & (awaddr_r == `UCTL_A_RXD));
	reg [31:0] cand;
	reg [31:0] base;

	// alias decode on the status/control word
	always @* begin
		base = {ctl_r[31:12], ctl_r[11] & ~(tx_done & brk_run_r), ctl_r[10:2], overrun_error_flag_r, ctl_r[0]};
		case (awaddr_r[3:2])
			2'h0: cand = (base & ~smask) | wdm;
			2'h1: cand = base & ~wdm;
			2'h2: cand = base | wdm;
			2'h3: cand = base ^ wdm;
			default: cand = base;
		endcase
	end

	wire nine_or_par = (pds != `UCTL_PDS_8N);
	wire rx_done = (rst_r == RX_DATA) & (rtick_r == BITC - 16'h0001) & (rbit_r == (nine_or_par ? 4'h9 : 4'h8));
	wire [8:0] char9 = nine ? rsh_r : (nine_or_par ? {1'b0, rsh_r[7:0]} : {1'b0, rsh_r[8:1]});
	// address filtering only in nine-bit mode
	wire drop_a = nine & ctl_r[`UCTL_B_STATION_DETECT_MODE] & ~char9[8];
	wire drop_m = nine & ctl_r[`UCTL_B_ADMEN] & char9[8] & (char9[7:0] != match);
	wire keep = rx_done & ~drop_a & ~drop_m;
	wire ovf = keep & (rcnt_r == `UCTL_DEPTH);
	wire overrun_error_flag_clr = wr_scr & overrun_error_flag_r & ~cand[`UCTL_B_OVERRUN_ERROR_FLAG];
	wire flush = overrun_error_flag_clr & ~ovf;

	// axi write channels, response after both
	always @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `UCTL_RESP_OK;
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_wr) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `UCTL_RESP_OK : `UCTL_RESP_ERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// control and configuration storage
	always @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			ctl_r <= `UCTL_SCR_RST;
			cfg_r <= `UCTL_CFG_RST;
			overrun_error_flag_r <= 1'b0;
		end else begin
			if (wr_scr) begin
				ctl_r <= (ctl_r & ~`UCTL_SCR_WMASK) | (cand & `UCTL_SCR_WMASK);
			end else if (tx_done && brk_run_r) begin
				ctl_r[`UCTL_B_BRK] <= 1'b0;
			end
			if (wr_cfg) begin
				cfg_r <= (cfg_r & ~`UCTL_CFG_WMASK) | (wdm & `UCTL_CFG_WMASK);
			end
			if (ovf) begin
				overrun_error_flag_r <= 1'b1;
			end else if (overrun_error_flag_clr) begin
				overrun_error_flag_r <= 1'b0;
			end
		end
	end

	// ****************************************
	// bus read side
	// ****************************************
	wire rd_hs = s_axi_arvalid & s_axi_arready;
	wire rd_pop = rd_hs & (s_axi_araddr == `UCTL_A_RXD) & rxda;

	always @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `UCTL_RESP_OK;
		end else begin
			if (rd_hs) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `UCTL_RESP_OK;
				case (s_axi_araddr)
					`UCTL_A_SCR: s_axi_rdata <= scr_rd;
					`UCTL_A_TXH: s_axi_rdata <= {23'h00_0000, tmem_r[twp_r - 2'h1]};
					`UCTL_A_RXD: s_axi_rdata <= {23'h00_0000, rhead[8:0]};
					`UCTL_A_CFG: s_axi_rdata <= cfg_r;
					`UCTL_A_CLR, `UCTL_A_SET, `UCTL_A_INV: s_axi_rdata <= 32'h0000_0000;
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `UCTL_RESP_ERR;
					end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ****************************************
	// transmit buffer and shifter
	// ****************************************
	wire t_push = wr_txh & txen & ~txbf;
	wire t_idle = ~tx_busy & ~tx_go_r & txen;
	wire t_brk = t_idle & ctl_r[`UCTL_B_BRK] & ~brk_run_r;
	wire t_pop = t_idle & ~t_brk & ~brk_run_r & (tcnt_r != 3'h0);

	always @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			twp_r <= 2'h0;
			trp_r <= 2'h0;
			tcnt_r <= 3'h0;
			tx_go_r <= 1'b0;
			tx_brk_r <= 1'b0;
			brk_run_r <= 1'b0;
		end else if (!txen) begin
			twp_r <= 2'h0;
			trp_r <= 2'h0;
			tcnt_r <= 3'h0;
			tx_go_r <= 1'b0;
			brk_run_r <= 1'b0;
		end else begin
			tx_go_r <= t_pop | t_brk;
			tx_brk_r <= t_brk;
			if (t_brk) begin
				brk_run_r <= 1'b1;
			end else if (tx_done) begin
				brk_run_r <= 1'b0;
			end
			if (t_push) begin
				twp_r <= twp_r + 2'h1;
			end
			if (t_pop) begin
				trp_r <= trp_r + 2'h1;
			end
			tcnt_r <= tcnt_r + {2'h0, t_push} - {2'h0, t_pop};
		end
	end

	always @(posedge clk_sys) begin
		if (t_push) begin
			tmem_r[twp_r] <= wdm[8:0];
		end
	end

	reg [8:0] tx_dat_r;
	always @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			tx_dat_r <= 9'h000;
		end else if (t_pop) begin
			tx_dat_r <= tmem_r[trp_r];
		end
	end

	uctl_tx u_tx (
		.clk_sys(clk_sys),
		.rst_s_n(rst_s_n),
		.abort(~txen),
		.start(tx_go_r),
		.brk(tx_brk_r),
		.pds(pds),
		.data(tx_dat_r),
		.line_r(tx_line),
		.busy_r(tx_busy),
		.done_r(tx_done)
	);

	// ****************************************
	// receive engine
	// ****************************************
	// three-stage sync; a level counts once stages two and three agree
	always @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
			filt_r <= 1'b1;
			filt_q <= 1'b1;
		end else begin
			s1_r <= serial_in_pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			filt_r <= (s2_r == s3_r) ? s3_r : filt_r;
			filt_q <= filt_r;
		end
	end

	// start detect at half bit, then one sample per bit time
	always @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			rst_r <= RX_IDLE;
			rtick_r <= 16'h0000;
			rbit_r <= 4'h0;
			rsh_r <= 9'h000;
		end else if (!rx_on || flush) begin
			rst_r <= RX_IDLE;
		end else begin
			rtick_r <= rtick_r + 16'h0001;
			case (rst_r)
				RX_IDLE: begin
					rtick_r <= 16'h0000;
					if (filt_q && !filt_r) begin
						rst_r <= RX_START;
					end
				end
				RX_START: begin
					if (rtick_r == (BITC >> 1)) begin
						rtick_r <= 16'h0000;
						rbit_r <= 4'h0;
						rst_r <= filt_r ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rtick_r == BITC - 16'h0001) begin
						rtick_r <= 16'h0000;
						rbit_r <= rbit_r + 4'h1;
						if (rx_done) begin
							rst_r <= RX_IDLE;
						end else begin
							rsh_r <= {filt_r, rsh_r[8:1]};
						end
					end
				end
				default: rst_r <= RX_IDLE;
			endcase
		end
	end

	// receive buffer; overrun drops the new character
	wire r_push = keep & ~ovf;
	wire parity_error_flag_now = nine_or_par & ~nine & ((^rsh_r) ^ pds[1]);

	always @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			rwp_r <= 2'h0;
			rrp_r <= 2'h0;
			rcnt_r <= 3'h0;
			rx_push_r <= 1'b0;
		end else if (flush) begin
			rwp_r <= 2'h0;
			rrp_r <= 2'h0;
			rcnt_r <= 3'h0;
			rx_push_r <= 1'b0;
		end else begin
			rx_push_r <= r_push;
			if (r_push) begin
				rwp_r <= rwp_r + 2'h1;
			end
			if (rd_pop) begin
				rrp_r <= rrp_r + 2'h1;
			end
			rcnt_r <= rcnt_r + {2'h0, r_push} - {2'h0, rd_pop};
		end
	end

	always @(posedge clk_sys) begin
		if (r_push) begin
			rmem_r[rwp_r] <= {parity_error_flag_now, ~filt_r, char9};
		end
	end

	// ****************************************
	// pins and interrupt requests
	// ****************************************
	always @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			serial_out_pin_r <= 1'b1;
			serial_out_oe_r <= 1'b0;
			serial_in_owned_r <= 1'b0;
			tx_irq_r <= 1'b0;
			rx_irq_r <= 1'b0;
			tcnt_q <= 3'h0;
		end else begin
			serial_out_pin_r <= (infrared_codec_enable ? ~tx_line : tx_line) ^ ctl_r[`UCTL_B_TXINV];
			serial_out_oe_r <= on & txen;
			serial_in_owned_r <= rx_on;
			tcnt_q <= tcnt_r;
			if (var2) begin
				case (txsel)
					2'h2: tx_irq_r <= (tcnt_r == 3'h0);
					2'h1: tx_irq_r <= transmit_shift_empty;
					2'h0: tx_irq_r <= ~txbf;
					default: tx_irq_r <= 1'b0;
				endcase
				case (rxsel)
					2'h1: rx_irq_r <= (rcnt_r == `UCTL_DEPTH);
					2'h0: rx_irq_r <= rxda;
					2'h2: rx_irq_r <= (rcnt_r >= 3'h3);
					default: rx_irq_r <= 1'b0;
				endcase
			end else begin
				case (txsel)
					2'h2: tx_irq_r <= (tcnt_r == 3'h0) & (tcnt_q != 3'h0);
					2'h0: tx_irq_r <= (tcnt_q == `UCTL_DEPTH) & ~txbf;
					default: tx_irq_r <= 1'b0;
				endcase
				case (rxsel)
					2'h3: rx_irq_r <= rx_push_r & (rcnt_r == `UCTL_DEPTH);
					2'h2: rx_irq_r <= rx_push_r & (rcnt_r == 3'h3);
					default: rx_irq_r <= rx_push_r;
				endcase
			end
		end
	end

endmodule // uctl_top

// ---- core/uctl_defs.vh ----
// constants for the serial status/control and transmit data block
`ifndef UCTL_DEFS_VH
`define UCTL_DEFS_VH

// register byte addresses (low address byte)
`define UCTL_A_SCR 8'h00
`define UCTL_A_CLR 8'h04
`define UCTL_A_SET 8'h08
`define UCTL_A_INV 8'h0C
`define UCTL_A_TXH 8'h10
`define UCTL_A_RXD 8'h14
`define UCTL_A_CFG 8'h18

// status/control field positions
`define UCTL_B_ADMEN 24
`define UCTL_B_MATCH_HI 23
`define UCTL_B_MATCH_LO 16
`define UCTL_B_TXSEL_HI 15
`define UCTL_B_TXSEL_LO 14
`define UCTL_B_TXINV 13
`define UCTL_B_RXEN 12
`define UCTL_B_BRK 11
`define UCTL_B_TXEN 10
`define UCTL_B_RXSEL_HI 7
`define UCTL_B_RXSEL_LO 6
`define UCTL_B_STATION_DETECT_MODE 5
`define UCTL_B_OVERRUN_ERROR_FLAG 1

// writable stored bits, overrun kept apart
`define UCTL_SCR_WMASK 32'h01FF_FCE0
`define UCTL_SCR_RST 32'h0000_0000

// configuration register fields
`define UCTL_B_ON 15
`define UCTL_B_INFRARED_CODEC_ENABLE 12
`define UCTL_B_VAR 16
`define UCTL_B_PDS_HI 2
`define UCTL_B_PDS_LO 1
`define UCTL_CFG_WMASK 32'h0001_9006
`define UCTL_CFG_RST 32'h0000_0000

// parity/data select codes
`define UCTL_PDS_8N 2'h0
`define UCTL_PDS_9N 2'h3

// buffer depth and bus answers
`define UCTL_DEPTH 3'h4
`define UCTL_RESP_OK 2'h0
`define UCTL_RESP_ERR 2'h2

// bit timing
`define UCTL_CLK_HZ 200000000
`define UCTL_BAUD 1000000
`define UCTL_BIT_CYC (`UCTL_CLK_HZ / `UCTL_BAUD)

`endif

// ---- core/uctl_tx.v ----
// serial frame shifter for data characters and break frames
`timescale 1ns/1ps
`include "uctl_defs.vh"

module uctl_tx (
	input wire clk_sys,
	input wire rst_s_n,
	input wire abort,
	input wire start,
	input wire brk,
	input wire [1:0] pds,
	input wire [8:0] data,
	output reg line_r,
	output reg busy_r,
	output reg done_r
);

	// bit time cut to the counter width on purpose
	localparam integer BITC_I = `UCTL_BIT_CYC;
	localparam [15:0] BITC = BITC_I[15:0];

	reg [13:0] sh_r;
	reg [3:0] left_r;
	reg [15:0] tick_r;
	wire par_bit;
	wire [8:0] top9;
	wire [13:0] frame;

	// ninth slot: data bit, parity, or the stop bit
	assign par_bit = (^data[7:0]) ^ pds[1];
	assign top9 = (pds == `UCTL_PDS_9N) ? data :
		((pds == `UCTL_PDS_8N) ? {1'b1, data[7:0]} : {par_bit, data[7:0]});
	assign frame = {4'hF, top9, 1'b0};

	// ****************************************
	// shifter
	// ****************************************
	always @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			sh_r <= 14'h3FFF;
			left_r <= 4'h0;
			tick_r <= 16'h0000;
			line_r <= 1'b1;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (abort) begin
				busy_r <= 1'b0;
				line_r <= 1'b1;
			end else if (!busy_r && start) begin
				sh_r <= brk ? 14'h2000 : frame;
				left_r <= brk ? 4'hE : ((pds == `UCTL_PDS_8N) ? 4'hA : 4'hB);
				tick_r <= 16'h0000;
				line_r <= 1'b0;
				busy_r <= 1'b1;
			end else if (busy_r) begin
				if (tick_r == BITC - 16'h0001) begin
					tick_r <= 16'h0000;
					sh_r <= {1'b1, sh_r[13:1]};
					left_r <= left_r - 4'h1;
					if (left_r == 4'h1) begin
						busy_r <= 1'b0;
						done_r <= 1'b1;
						line_r <= 1'b1;
					end else begin
						line_r <= sh_r[1];
					end
				end else begin
					tick_r <= tick_r + 16'h0001;
				end
			end
		end
	end

endmodule // uctl_tx

// ---- bench/uctl_peer.sv ----
// remote serial peer: sends frames on the receive line, samples the transmit line
`timescale 1ns/1ps
`include "uctl_defs.vh"

module uctl_peer (
	input wire logic clk_sys,
	input wire logic line_in,
	output logic line_out
);
	localparam int BIT = `UCTL_BIT_CYC;

	// line idles high between frames, as a real peer holds it
	initial line_out = 1'b1;

	// start, n data bits lsb first, stop level, then one idle bit as gap
	task automatic send(input logic [8:0] ch, input int n, input logic stp);
		line_out <= 1'b0;
		repeat (BIT) @(posedge clk_sys);
		for (int i = 0; i < n; i++) begin
			line_out <= ch[i];
			repeat (BIT) @(posedge clk_sys);
		end
		line_out <= stp;
		repeat (BIT) @(posedge clk_sys);
		line_out <= 1'b1;
		repeat (BIT) @(posedge clk_sys);
	endtask

	// mid-bit sampling; must be armed before the start edge or the frame is missed
	task automatic recv(input int n, output logic [12:0] d, output logic stp);
		d = 13'h0000;
		@(negedge line_in);
		repeat (BIT / 2) @(posedge clk_sys);
		for (int i = 0; i < n; i++) begin
			repeat (BIT) @(posedge clk_sys);
			d[i] = line_in;
		end
		repeat (BIT) @(posedge clk_sys);
		stp = line_in;
	endtask
endmodule // uctl_peer

// ---- bench/uctl_top_assertions.sv ----
// bus answer checks on the ports of the serial status/control block
`timescale 1ns/1ps
`include "uctl_defs.vh"

module uctl_top_assertions (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic [7:0] aw_q;
	logic [7:0] ar_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// addresses of the transfer in flight, for judging the answer
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			aw_q <= 8'h00;
			ar_q <= 8'h00;
		end else begin
			if (s_axi_awvalid && s_axi_awready)
				aw_q <= s_axi_awaddr;
			if (s_axi_arvalid && s_axi_arready)
				ar_q <= s_axi_araddr;
		end
	end

	AST_AW_TAKEN: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("awready high after address taken");
	AST_AR_TAKEN: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
	AST_B_RESP: assert property (s_axi_bvalid && aw_q[1:0] == 2'h0 |-> s_axi_bresp
		== (aw_q > 8'h18 ? `UCTL_RESP_ERR : `UCTL_RESP_OK)) else $error("bad bresp");
	AST_R_RESP: assert property (s_axi_rvalid && ar_q[1:0] == 2'h0 |-> s_axi_rresp
		== (ar_q > 8'h18 ? `UCTL_RESP_ERR : `UCTL_RESP_OK)) else $error("bad rresp");
	AST_ERR_DATA: assert property (s_axi_rvalid && ar_q > 8'h18
		|-> s_axi_rdata == 32'h0000_0000) else $error("unmapped read data");
	AST_ALIAS_RD: assert property (
		s_axi_rvalid && (ar_q == 8'h04 || ar_q == 8'h08 || ar_q == 8'h0C)
		|-> s_axi_rdata == 32'h0000_0000) else $error("alias read not zero");
endmodule // uctl_top_assertions

bind uctl_top uctl_top_assertions chk_i (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready);

// ---- bench/test_uart_status_control_and_tx_data.sv ----
// self-checking bench for the serial status/control block
`timescale 1ns/1ps
`include "uctl_defs.vh"

module test_uart_status_control_and_tx_data;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, rd;
	logic serial_in_pin, serial_in_owned_r, serial_out_pin_r, serial_out_oe_r;
	logic tx_irq_r, rx_irq_r, stp;
	logic [1:0] resp;
	logic [12:0] bits;
	int num_errors = 0, checks = 0;
	int tx_pulses = 0, rx_pulses = 0;
	// released transmit pin is pulled up
	wire tx_line = serial_out_oe_r ? serial_out_pin_r : 1'b1;

	uctl_top uut (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .serial_in_pin, .serial_in_owned_r, .serial_out_pin_r, .serial_out_oe_r,
		.tx_irq_r, .rx_irq_r);
	uctl_peer peer (.clk_sys, .line_in(tx_line), .line_out(serial_in_pin));

	initial forever #2.5 clk_sys = ~clk_sys;

	// request pulses counted, for judging the edge variant
	always @(posedge clk_sys) begin
		if (tx_irq_r)
			tx_pulses <= tx_pulses + 1;
		if (rx_irq_r)
			rx_pulses <= rx_pulses + 1;
	end

	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b1;
		// response taken at the edge that sees bready high
		@(posedge clk_sys);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// read then compare under a mask; rready raised late on purpose
	task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b1;
		@(posedge clk_sys);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		chk(rd & m, e);
	endtask

	task automatic t_regs;
		rdm(`UCTL_A_SCR, 32'hFFFF_FFFF, 32'h0000_0110);
		rdm(`UCTL_A_CLR, 32'hFFFF_FFFF, 32'h0000_0000);
		rdm(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
		chk(resp, `UCTL_RESP_ERR);
		axi_wr(8'h40, 32'hFFFF_FFFF);
		chk(resp, `UCTL_RESP_ERR);
		axi_wr(`UCTL_A_SCR, 32'h00AB_0000);
		rdm(`UCTL_A_SCR, 32'hFFFF_FFFF, 32'h00AB_0110);
		axi_wr(`UCTL_A_SET, 32'h0100_031D);
		rdm(`UCTL_A_SCR, 32'hFFFF_FFFF, 32'h01AB_0110);
		axi_wr(`UCTL_A_INV, 32'h01FF_0000);
		rdm(`UCTL_A_SCR, 32'hFFFF_FFFF, 32'h0054_0110);
		axi_wr(`UCTL_A_CLR, 32'h0054_0000);
		rdm(`UCTL_A_SCR, 32'hFFFF_FFFF, 32'h0000_0110);
		$display("t_regs done");
	endtask

	task automatic t_tx;
		axi_wr(`UCTL_A_SET, 32'h0000_0400);
		repeat (2) @(posedge clk_sys);
		chk(serial_out_oe_r, 1);
		fork
			peer.recv(8, bits, stp);
			axi_wr(`UCTL_A_TXH, 32'h0000_00A5);
		join
		chk(bits, 13'h00A5);
		chk(stp, 1);
		// shifter still busy: four fill the buffer, the last two are refused
		repeat (6) axi_wr(`UCTL_A_TXH, 32'h0000_0055);
		rdm(`UCTL_A_SCR, 32'h0000_0300, 32'h0000_0200);
		chk(tx_irq_r, 0);
		axi_wr(`UCTL_A_CLR, 32'h0000_0400);
		repeat (2) @(posedge clk_sys);
		chk(serial_out_oe_r, 0);
		rdm(`UCTL_A_SCR, 32'h0000_0300, 32'h0000_0100);
		$display("t_tx done");
	endtask

	task automatic t_brk;
		axi_wr(`UCTL_A_SET, 32'h0000_0400);
		fork
			peer.recv(12, bits, stp);
			axi_wr(`UCTL_A_SET, 32'h0000_0800);
		join
		chk(bits, 13'h0000);
		chk(stp, 1);
		repeat (150) @(posedge clk_sys);
		rdm(`UCTL_A_SCR, 32'h0000_0900, 32'h0000_0100);
		$display("t_brk done");
	endtask

	task automatic t_pol;
		for (int i = 0; i < 4; i++) begin
			axi_wr(`UCTL_A_CFG, i < 2 ? 32'h0001_8000 : 32'h0001_9000);
			axi_wr(`UCTL_A_SCR, i[0] ? 32'h0000_0400 : 32'h0000_2400);
			repeat (2) @(posedge clk_sys);
			chk(serial_out_pin_r, 4'b0110 >> i & 1);
		end
		axi_wr(`UCTL_A_CFG, 32'h0001_8000);
		$display("t_pol done");
	endtask

	task automatic t_rx;
		peer.send(9'h03C, 8, 1'b1);
		rdm(`UCTL_A_SCR, 32'h0000_0001, 32'h0000_0000);
		axi_wr(`UCTL_A_SET, 32'h0000_1000);
		repeat (2) @(posedge clk_sys);
		chk(serial_in_owned_r, 1);
		fork
			peer.send(9'h03C, 8, 1'b1);
			begin
				repeat (900) @(posedge clk_sys);
				rdm(`UCTL_A_SCR, 32'h0000_0011, 32'h0000_0000);
			end
		join
		rdm(`UCTL_A_SCR, 32'h0000_001D, 32'h0000_0011);
		chk(rx_irq_r, 1);
		rdm(`UCTL_A_RXD, 32'h0000_01FF, 32'h0000_003C);
		rdm(`UCTL_A_SCR, 32'h0000_0001, 32'h0000_0000);
		chk(rx_irq_r, 0);
		peer.send(9'h0F0, 8, 1'b0);
		rdm(`UCTL_A_SCR, 32'h0000_0005, 32'h0000_0005);
		rdm(`UCTL_A_RXD, 32'h0000_01FF, 32'h0000_00F0);
		axi_wr(`UCTL_A_CFG, 32'h0001_8002);
		peer.send(9'h001, 9, 1'b1);
		rdm(`UCTL_A_SCR, 32'h0000_0009, 32'h0000_0009);
		rdm(`UCTL_A_RXD, 32'h0000_01FF, 32'h0000_0001);
		axi_wr(`UCTL_A_CFG, 32'h0001_8000);
		repeat (5) peer.send(9'h011, 8, 1'b1);
		rdm(`UCTL_A_SCR, 32'h0000_0003, 32'h0000_0003);
		axi_wr(`UCTL_A_CLR, 32'h0000_0002);
		rdm(`UCTL_A_SCR, 32'h0000_0003, 32'h0000_0000);
		$display("t_rx done");
	endtask

	// nine-bit mode: data chars and foreign addresses dropped, own address kept
	task automatic t_nine;
		axi_wr(`UCTL_A_CFG, 32'h0001_8006);
		axi_wr(`UCTL_A_SET, 32'h015A_0020);
		peer.send(9'h03C, 9, 1'b1);
		peer.send(9'h1A5, 9, 1'b1);
		rdm(`UCTL_A_SCR, 32'h0000_0001, 32'h0000_0000);
		peer.send(9'h15A, 9, 1'b1);
		rdm(`UCTL_A_RXD, 32'h0000_01FF, 32'h0000_015A);
		$display("t_nine done");
	endtask

	// first variant: one pulse per event, not a level
	task automatic t_var1;
		int t0;
		int r0;
		axi_wr(`UCTL_A_CFG, 32'h0000_8000);
		axi_wr(`UCTL_A_SCR, 32'h0000_9400);
		t0 = tx_pulses;
		r0 = rx_pulses;
		fork
			peer.send(9'h024, 8, 1'b1);
			axi_wr(`UCTL_A_TXH, 32'h0000_0033);
		join
		peer.send(9'h024, 8, 1'b1);
		chk(tx_pulses - t0, 1);
		chk(rx_pulses - r0, 2);
		rdm(`UCTL_A_RXD, 32'h0000_01FF, 32'h0000_0024);
		$display("t_var1 done");
	endtask

	initial begin
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_regs;
		axi_wr(`UCTL_A_CFG, 32'h0001_8000);
		t_tx;
		t_brk;
		t_pol;
		t_rx;
		t_nine;
		t_var1;
		wrap_up;
	end

	// cut a hang short well past the expected run length
	initial begin
		repeat (90000) @(posedge clk_sys);
		num_errors++;
		wrap_up;
	end
endmodule // test_uart_status_control_and_tx_data
